/* hdl/afd_pkg.sv */
// Shared constants and types for the audio FIFO and DMA request block
package afd_pkg;
    // ==========================================================
    // Storage geometry
    localparam int unsigned AFD_DATA_W     = 32;
    localparam int unsigned AFD_FIFO_DEPTH = 64;
    localparam int unsigned AFD_CNT_W      = 7;
    // ==========================================================
    // Control word layout: threshold field sits in bits 15:8
    localparam int unsigned AFD_THR_LSB    = 8;
    localparam int unsigned AFD_THR_MSB    = 15;
    localparam int unsigned AFD_THR_W      = 8;
    localparam logic [31:0] AFD_CTL_RESET  = 32'h0000_0100;
    // ==========================================================
    // Request set/clear window in cycles
    localparam int unsigned AFD_COLLIDE_WIN = 2;
    typedef logic [AFD_CNT_W-1:0] afd_cnt_t;
    typedef logic [AFD_THR_W-1:0] afd_thr_t;
endpackage : afd_pkg

/* hdl/afd_fifo_if.sv */
// Stream carrier between the FIFO and its users
`timescale 1ns/1ns
interface afd_fifo_if #(parameter int unsigned W = 32);
    logic         in_valid;
    logic         in_ready;
    logic [W-1:0] in_data;
    logic         out_valid;
    logic         out_ready;
    logic [W-1:0] out_data;
    logic [6:0]   level;
    modport fifo (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data, level);
    modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data, level);
endinterface : afd_fifo_if

/* hdl/afd_fifo.sv */
// Parameterised flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ns
module afd_fifo
    import afd_pkg::*;
#(
    parameter int unsigned W     = 32,
    parameter int unsigned DEPTH = 64
) (
    input wire logic clk,
    input wire logic rst_n,
    afd_fifo_if.fifo f
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0]   count;
    logic          push;
    logic          pop;

    // ==========================================================
    // Handshakes: honest full and empty
    assign f.in_ready  = (count != (AW+1)'(DEPTH));
    assign f.out_valid = (count != '0);
    assign f.out_data  = mem[rd_ptr];
    assign f.level     = 7'(count);
    assign push        = f.in_valid && f.in_ready;
    assign pop         = f.out_valid && f.out_ready;

    // Storage write, no reset needed on data
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= f.in_data;
        end
    end

    // Pointers and fill count
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= AW'(wr_ptr + 1'b1);
            end
            if (pop) begin
                rd_ptr <= AW'(rd_ptr + 1'b1);
            end
            count <= (AW+1)'(count + (AW+1)'(push) - (AW+1)'(pop));
        end
    end
endmodule : afd_fifo

/* hdl/afd_dma_fifo.sv */
// Receive and transmit FIFOs with threshold-based DMA request logic
`timescale 1ns/1ns
// What this block does
// - A pending request drops once the DMA side has moved a threshold number of words.
// - A request rises once the pin side has moved a threshold number of words.
// - When a set and a clear meet within two cycles the request ends up asserted.
// - Each direction has a programmable threshold in bits 15 to 8 of its control word.
// - Each direction holds sixty-four data words.
// - Unserviced receive overflows and unserviced transmit underflows, both sticky until software clears.
module afd_dma_fifo
    import afd_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic [31:0]           rx_fifo_control,
    input  wire logic [31:0]           tx_fifo_control,
    input  wire logic                  err_clear,
    input  wire logic                  rx_pin_valid,
    input  wire logic [AFD_DATA_W-1:0] rx_pin_data,
    input  wire logic                  rx_dma_rd,
    output logic      [AFD_DATA_W-1:0] rx_dma_data,
    output logic                       rx_dma_req,
    input  wire logic                  tx_dma_wr,
    input  wire logic [AFD_DATA_W-1:0] tx_dma_data,
    input  wire logic                  tx_pin_take,
    output logic      [AFD_DATA_W-1:0] tx_pin_data,
    output logic                       tx_dma_req,
    output logic                       rx_overflow,
    output logic                       tx_underflow
);
    afd_fifo_if #(.W(AFD_DATA_W)) rxf ();
    afd_fifo_if #(.W(AFD_DATA_W)) txf ();

    afd_thr_t rx_request_threshold;
    afd_thr_t tx_request_threshold;
    afd_thr_t rx_pin_cnt;
    afd_thr_t rx_dma_cnt;
    afd_thr_t tx_pin_cnt;
    afd_thr_t tx_dma_cnt;
    logic     rx_set;
    logic     rx_clr;
    logic     tx_set;
    logic     tx_clr;
    logic     rx_push;
    logic     rx_pop;
    logic     tx_push;
    logic     tx_pop;
    afd_cnt_t rx_pend;
    afd_cnt_t tx_pend;
    afd_cnt_t next_rx_pend;
    afd_cnt_t next_tx_pend;

    // Threshold of zero is treated as one so a request can still fire
    function automatic afd_thr_t thr_of(input logic [31:0] ctl);
        afd_thr_t t;
        t = ctl[AFD_THR_MSB:AFD_THR_LSB];
        return (t == '0) ? afd_thr_t'(1) : t;
    endfunction : thr_of

    // Wraps a word counter at the threshold and flags the crossing
    function automatic afd_thr_t cnt_next(input afd_thr_t c, input afd_thr_t thr);
        return (afd_thr_t'(c + 1'b1) >= thr) ? '0 : afd_thr_t'(c + 1'b1);
    endfunction : cnt_next

    function automatic logic cnt_hit(input afd_thr_t c, input afd_thr_t thr);
        return afd_thr_t'(c + 1'b1) >= thr;
    endfunction : cnt_hit

    // Outstanding-request count; a set in the clearing cycle still leaves one pending.
    // Saturates at both ends so a clear with nothing outstanding (a priming write) is absorbed.
    function automatic afd_cnt_t pend_next(input afd_cnt_t p, input logic set, input logic clr);
        afd_cnt_t r;
        r = p;
        if (set && clr) begin
            r = (p == '0) ? afd_cnt_t'(1) : p;
        end else if (set) begin
            r = (p == '1) ? p : afd_cnt_t'(p + 1'b1);
        end else if (clr) begin
            r = (p == '0) ? p : afd_cnt_t'(p - 1'b1);
        end
        return r;
    endfunction : pend_next

    // ==========================================================
    // Storage
    // sixty-four words
    afd_fifo #(.W(AFD_DATA_W), .DEPTH(AFD_FIFO_DEPTH)) u_rx_fifo (
        .clk   (clk),
        .rst_n (rst_n),
        .f     (rxf.fifo)
    );
    afd_fifo #(.W(AFD_DATA_W), .DEPTH(AFD_FIFO_DEPTH)) u_tx_fifo (
        .clk   (clk),
        .rst_n (rst_n),
        .f     (txf.fifo)
    );

    assign rx_request_threshold = thr_of(rx_fifo_control);
    assign tx_request_threshold = thr_of(tx_fifo_control);

    // Pin-side pushes are dropped when full; that is the overflow case
    assign rxf.in_valid  = rx_pin_valid;
    assign rxf.in_data   = rx_pin_data;
    assign rxf.out_ready = rx_dma_rd;
    assign txf.in_valid  = tx_dma_wr;
    assign txf.in_data   = tx_dma_data;
    assign txf.out_ready = tx_pin_take;

    assign rx_push = rx_pin_valid && rxf.in_ready;
    assign rx_pop  = rx_dma_rd && rxf.out_valid;
    assign tx_push = tx_dma_wr && txf.in_ready;
    assign tx_pop  = tx_pin_take && txf.out_valid;

    // ==========================================================
    // Word counters per side
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_pin_cnt <= '0;
            rx_dma_cnt <= '0;
            tx_pin_cnt <= '0;
            tx_dma_cnt <= '0;
        end else begin
            if (rx_push) begin
                rx_pin_cnt <= cnt_next(rx_pin_cnt, rx_request_threshold);
            end
            if (rx_pop) begin
                rx_dma_cnt <= cnt_next(rx_dma_cnt, rx_request_threshold);
            end
            if (tx_pop) begin
                tx_pin_cnt <= cnt_next(tx_pin_cnt, tx_request_threshold);
            end
            if (tx_push) begin
                tx_dma_cnt <= cnt_next(tx_dma_cnt, tx_request_threshold);
            end
        end
    end

    assign rx_set = rx_push && cnt_hit(rx_pin_cnt, rx_request_threshold);
    assign tx_set = tx_pop && cnt_hit(tx_pin_cnt, tx_request_threshold);
    // DMA moves threshold words per request
    assign rx_clr = rx_pop && cnt_hit(rx_dma_cnt, rx_request_threshold);
    assign tx_clr = tx_push && cnt_hit(tx_dma_cnt, tx_request_threshold);

    // ==========================================================
    // Request bookkeeping counts outstanding requests rather than keeping a bare flag.
    // A bare flag loses a new request whose set lands a cycle before the clear of the
    // previous one; the count keeps it alive until its own words have moved.
    // Trade-off: a few extra flops per direction for a request that is never dropped.
    // set beats clear
    assign next_rx_pend = pend_next(rx_pend, rx_set, rx_clr);
    assign next_tx_pend = pend_next(tx_pend, tx_set, tx_clr);

    // Outstanding counts
    // reset empties counts
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_pend <= '0;
            tx_pend <= '0;
        end else begin
            rx_pend <= next_rx_pend;
            tx_pend <= next_tx_pend;
        end
    end

    // Request outputs follow the next count so they stay one flop deep
    // reset drops requests
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_dma_req <= 1'b0;
            tx_dma_req <= 1'b0;
        end else begin
            rx_dma_req <= (next_rx_pend != '0);
            tx_dma_req <= (next_tx_pend != '0);
        end
    end

    // ==========================================================
    // Error flags; an event in the clearing cycle still sets
    // sticky overflow and underflow
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_overflow  <= 1'b0;
            tx_underflow <= 1'b0;
        end else begin
            if (rx_pin_valid && !rxf.in_ready) begin
                rx_overflow <= 1'b1;
            end else if (err_clear) begin
                rx_overflow <= 1'b0;
            end
            if (tx_pin_take && !txf.out_valid) begin
                tx_underflow <= 1'b1;
            end else if (err_clear) begin
                tx_underflow <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Registered data outputs, valid the cycle after the pop
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_dma_data <= '0;
            tx_pin_data <= '0;
        end else begin
            if (rx_pop) begin
                rx_dma_data <= rxf.out_data;
            end
            if (tx_pop) begin
                tx_pin_data <= txf.out_data;
            end
        end
    end
endmodule : afd_dma_fifo

/* verif/afd_dma_fifo_sva.sv */
// Port-level assertions for the DMA request block
`timescale 1ns/1ns
module afd_dma_fifo_sva (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic err_clear,
    input wire logic rx_pin_valid,
    input wire logic rx_dma_rd,
    input wire logic rx_dma_req,
    input wire logic tx_dma_wr,
    input wire logic tx_pin_take,
    input wire logic tx_dma_req,
    input wire logic rx_overflow,
    input wire logic tx_underflow
);
    // ==========================================================
    // Request and error flag timing, all on one clock
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_reset_quiet: assert property ($rose(rst_n) |-> !rx_dma_req && !tx_dma_req) else $error("req after reset");
    a_rx_set_cause: assert property ($rose(rx_dma_req) |-> $past(rx_pin_valid)) else $error("rx req unprompted");
    a_tx_set_cause: assert property ($rose(tx_dma_req) |-> $past(tx_pin_take)) else $error("tx req unprompted");
    a_rx_clr_cause: assert property ($fell(rx_dma_req) |-> $past(rx_dma_rd)) else $error("rx req dropped");
    a_tx_clr_cause: assert property ($fell(tx_dma_req) |-> $past(tx_dma_wr)) else $error("tx req dropped");
    a_rx_req_held: assert property (rx_dma_req && !rx_dma_rd |=> rx_dma_req) else $error("rx req lost");
    a_ovf_sticky: assert property (rx_overflow && !err_clear |=> rx_overflow) else $error("ovf not sticky");
    a_unf_cause: assert property ($rose(tx_underflow) |-> $past(tx_pin_take)) else $error("unf unprompted");
    a_err_clears: assert property (err_clear && !rx_pin_valid && !tx_pin_take |=> !rx_overflow && !tx_underflow)
        else $error("flags not cleared");
    // Main scenarios reached
    c_collide: cover property (rx_dma_req && rx_dma_rd && rx_pin_valid);
    c_overflow: cover property (rx_overflow);
    c_underflow: cover property (tx_underflow);
endmodule : afd_dma_fifo_sva

/* verif/afd_dma_model.sv */
// Behavioural DMA controller serving both request lines
`timescale 1ns/1ns
module afd_dma_model
    import afd_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic                  en,
    input  wire logic                  prime,
    input  wire logic [31:0]           rx_ctl,
    input  wire logic [31:0]           tx_ctl,
    input  wire logic                  rx_dma_req,
    output logic                       rx_dma_rd,
    input  wire logic                  tx_dma_req,
    output logic                       tx_dma_wr,
    output logic      [AFD_DATA_W-1:0] tx_dma_data
);
    // ==========================================================
    // Burst engines: threshold words, then three idle cycles so a stale request is not served twice
    logic [8:0]  rx_left;
    logic [8:0]  tx_left;
    logic [15:0] seq;
    assign rx_dma_rd   = rx_left > 9'h002;
    assign tx_dma_wr   = tx_left > 9'h002;
    // Data lines show the inverted word pattern outside writes
    assign tx_dma_data = tx_dma_wr ? {16'hC0DE, seq} : ~{16'hC0DE, seq};
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_left <= 9'h000;
            tx_left <= 9'h000;
            seq     <= 16'h0000;
        end else begin
            rx_left <= (rx_left != 9'h000) ? rx_left - 9'h001 : (en && rx_dma_req) ? {1'b0, rx_ctl[15:8]} + 9'h002 : 9'h000;
            tx_left <= (tx_left != 9'h000) ? tx_left - 9'h001
                     : (en && (tx_dma_req || prime)) ? {1'b0, tx_ctl[15:8]} + 9'h002 : 9'h000;
            seq     <= seq + {15'h0000, tx_dma_wr};
        end
    end
endmodule : afd_dma_model

/* verif/test_afd_dma_fifo.sv */
// Self-checking bench for the DMA request block
`timescale 1ns/1ns
module test_afd_dma_fifo;
    import afd_pkg::*;
    logic                  clk, rst_n, en, prime, err_clear, rx_pin_valid, tx_pin_take, rx_dma_rd, tx_dma_wr;
    logic                  rx_dma_req, tx_dma_req, rx_overflow, tx_underflow, rd_q;
    logic [31:0]           rxc, txc;
    logic [AFD_DATA_W-1:0] rx_pin_data, rx_dma_data, tx_dma_data, tx_pin_data;
    logic [31:0]           exp_q[$];
    int                    error_cnt, total_checks, nw, n_rd;
    // ==========================================================
    // Clock, design and far-side model
    always #4 clk = ~clk;
    afd_dma_fifo dut (.clk, .rst_n, .rx_fifo_control(rxc), .tx_fifo_control(txc), .err_clear, .rx_pin_valid,
        .rx_pin_data, .rx_dma_rd, .rx_dma_data, .rx_dma_req, .tx_dma_wr, .tx_dma_data, .tx_pin_take,
        .tx_pin_data, .tx_dma_req, .rx_overflow, .tx_underflow);
    afd_dma_model dma (.clk, .rst_n, .en, .prime, .rx_ctl(rxc), .tx_ctl(txc), .rx_dma_req, .rx_dma_rd,
        .tx_dma_req, .tx_dma_wr, .tx_dma_data);
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task final_report();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : final_report
    // One cycle of pin-side stimulus; acc says whether the word should land
    task step(input logic pv, input logic tk, input logic acc);
        rx_pin_valid = pv;
        tx_pin_take  = tk;
        rx_pin_data  = 32'hAB00_0000 + nw;
        if (pv && acc) exp_q.push_back(rx_pin_data);
        nw++;
        @(posedge clk);
        #1;
    endtask : step
    // Bounded wait: 0 read strobe, 1 rx request low, 2 tx request low
    task wt(input int s);
        int i;
        for (i = 0; i < 300; i++) begin
            if (s == 0 ? rx_dma_rd === 1'b1 : s == 1 ? rx_dma_req === 1'b0 : tx_dma_req === 1'b0) break;
            step(0, 0, 0);
        end
        if (i == 300) begin
            chk("wait bound", 0, 1);
            final_report();
        end
    endtask : wt
    // Every DMA read is compared, in order, with what the pins delivered
    always @(posedge clk) begin
        if (rd_q) chk("rx data", rx_dma_data, exp_q.pop_front());
        if (rx_dma_rd === 1'b1) n_rd++;
        rd_q <= rx_dma_rd;
    end
    task s_rx_basic();
        // threshold of four, so four words per request
        rxc = 32'h0000_0400;
        repeat (3) step(1, 0, 1);
        chk("rx req early", rx_dma_req, 0);
        step(1, 0, 1);
        chk("rx req set", rx_dma_req, 1);
        repeat (3) step(0, 0, 0);
        chk("rx req held", rx_dma_req, 1);
        en = 1;
        wt(1);
        chk("rx reads", n_rd, 4);
    endtask : s_rx_basic
    task s_collide();
        int i, b;
        rxc = 32'h0000_0200;
        b = n_rd;
        repeat (2) step(1, 0, 1);
        // i[1]: set one cycle before the clear; otherwise i[0] picks clear first or same cycle
        for (i = 0; i < 8; i++) begin
            if (i[1]) step(1, 0, 1);
            wt(0);
            if (!i[1]) step(1, 0, 1);
            if (i[0] && !i[1]) step(0, 0, 0);
            step(1, 0, 1);
            if (i[1]) step(0, 0, 0);
            chk("rx req kept", rx_dma_req, 1);
        end
        wt(1);
        chk("rx words", n_rd - b, 18);
    endtask : s_collide
    task s_overflow();
        en = 0;
        rxc = 32'h0000_4000;
        repeat (64) step(1, 0, 1);
        chk("rx ovf early", rx_overflow, 0);
        step(1, 0, 0);
        chk("rx ovf", {rx_overflow, rx_dma_req}, 3);
        err_clear = 1;
        step(0, 0, 0);
        err_clear = 0;
        chk("rx ovf clr", rx_overflow, 0);
        en = 1;
        wt(1);
    endtask : s_overflow
    task s_tx();
        int i;
        txc = 32'h0000_0400;
        prime = 1;
        step(0, 0, 0);
        prime = 0;
        repeat (8) step(0, 0, 0);
        for (i = 0; i < 9; i++) begin
            if (i == 4) wt(2);
            if (i == 4) en = 0;
            if (i == 8) err_clear = 1;
            step(0, i < 8, 0);
            if (i < 8) chk("tx data", tx_pin_data, {16'hC0DE, i[15:0]});
        end
        err_clear = 0;
        chk("tx req pending", tx_dma_req, 1);
        step(0, 1, 0);
        chk("tx unf", tx_underflow, 1);
        en = 1;
        wt(2);
        chk("tx refill", tx_dma_req, 0);
        // Refilled words come out in the order the DMA wrote them
        for (i = 0; i < 4; i++) begin
            step(0, 1, 0);
            chk("tx refill data", tx_pin_data, {16'hC0DE, 16'(i + 8)});
        end
    endtask : s_tx
    initial begin
        {clk, rst_n, en, prime, err_clear, rx_pin_valid, tx_pin_take, rd_q, rx_pin_data} = '0;
        {rxc, txc} = {AFD_CTL_RESET, AFD_CTL_RESET};
        repeat (20) @(posedge clk);
        #1;
        rst_n = 1;
        chk("reset", {rx_dma_req, tx_dma_req, rx_overflow, tx_underflow}, 0);
        s_rx_basic();
        s_collide();
        s_overflow();
        s_tx();
        final_report();
    end
endmodule : test_afd_dma_fifo
bind afd_dma_fifo afd_dma_fifo_sva u_sva (.clk, .rst_n, .err_clear, .rx_pin_valid, .rx_dma_rd, .rx_dma_req,
    .tx_dma_wr, .tx_pin_take, .tx_dma_req, .rx_overflow, .tx_underflow);
